// [bench/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model
(
    // clock and device status
    input wire logic       clk_in,
    input wire logic       cmd_ready_in,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] pop_byte_in,
    // requests to the device, and the hang_out timeout flag
    output var logic       cmd_valid_out,
    output var logic [7:0] cmd_byte_out,
    output var logic       push_valid_out,
    output var logic [7:0] push_byte_out,
    output var logic       pop_req_out,
    output var logic       hang_out
);
initial
begin
    cmd_valid_out = 1'b0;
    cmd_byte_out = 8'h00;
    push_valid_out = 1'b0;
    push_byte_out = 8'h00;
    pop_req_out = 1'b0;
    hang_out = 1'b0;
end
// push n bytes, least significant first; lines inverted once released
task put(input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++)
    begin
        @(posedge clk_in);
        push_valid_out <= 1'b1;
        push_byte_out <= v[8*i +: 8];
        @(posedge clk_in);
        push_valid_out <= 1'b0;
        push_byte_out <= ~v[8*i +: 8];
    end
endtask
// pop n bytes, most significant first
task get(input int n, output logic [31:0] v);
    v = 32'h00000000;
    for (int i = 0; i < n; i++)
    begin
        @(posedge clk_in);
        pop_req_out <= 1'b1;
        @(posedge clk_in);
        pop_req_out <= 1'b0;
        #1 v = {v[23:0], pop_byte_in};
    end
endtask
// issue one command, optionally wait for completion
task run(input logic [7:0] c, input bit wait_done);
    int k;
    for (k = 0; k < 13000 && cmd_ready_in !== 1'b1; k++)
        @(posedge clk_in);
    if (k >= 13000)
        hang_out = 1'b1;
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_byte_out <= c;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_byte_out <= ~c;
    #1;
    for (k = 0; wait_done && k < 13000 && flags_in[7] !== 1'b0; k++)
        @(posedge clk_in) #1;
    if (k >= 13000)
        hang_out = 1'b1;
endtask
endmodule // host_model
`default_nettype wire

// [bench/stack_unit_props.sv]
`timescale 1ns/100ps
`default_nettype none
`include "stack_arith_map.vh"
module stack_unit_props
(
    // clock and reset
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    // command and operand entry
    input wire logic       cmd_valid_in,
    input wire logic [7:0] cmd_byte_in,
    input wire logic       push_valid_in,
    input wire logic [7:0] push_byte_in,
    input wire logic       pop_req_in,
    // results
    input wire logic [7:0] pop_byte_out,
    input wire logic [7:0] result_flags_out,
    input wire logic       service_request_output,
    input wire logic       cmd_ready_out
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (sys_rst_in);
// ****************
// helper logic
// ****************
wire logic busy = result_flags_out[`FLAG_BUSY_BIT];
wire logic take = cmd_valid_in && cmd_ready_out;
logic [6:0]  op_q;
logic        srq_q;
logic [13:0] cnt_q;
// capture the command and count its busy cycles
always_ff @(posedge clk_in)
begin
    if (sys_rst_in)
    begin
        op_q <= 7'h00;
        srq_q <= 1'b0;
        cnt_q <= 14'h0000;
    end
    else if (take)
    begin
        op_q <= cmd_byte_in[6:0];
        srq_q <= cmd_byte_in[`CMD_SRQ_BIT];
        cnt_q <= 14'h0000;
    end
    else if (busy)
        cnt_q <= cnt_q + 14'h0001;
end
// expected busy length, zero for ops not tracked
function automatic logic [13:0] lat(input logic [6:0] op);
    case (op)
        `OP_NO_OPERATION: lat = `CYC_NO_OPERATION;
        `OP_SGL_ADD: lat = `CYC_SGL_ADD;
        `OP_SGL_SUB: lat = `CYC_SGL_SUB;
        `OP_DBL_ADD: lat = `CYC_DBL_ADD;
        `OP_FLOAT_MUL: lat = `CYC_FLOAT_MUL;
        `OP_SQUARE_ROOT: lat = `CYC_SQUARE_ROOT;
        `OP_NEGS: lat = `CYC_NEGS;
        `OP_NEGD: lat = `CYC_NEGD;
        `OP_SWAPD: lat = `CYC_SWAP;
        `OP_PUSHD: lat = `CYC_STACK;
        default: lat = 14'h0000;
    endcase
endfunction
// ****************
// assertions
// ****************
sequence s_take_idle_cmd;
    take && (cmd_byte_in[6:0] == `OP_NO_OPERATION);
endsequence
sequence s_idle_cmd_run;
    busy [*4] ##1 !busy;
endsequence
a_idle_cmd_busy: assert property (s_take_idle_cmd |=> s_idle_cmd_run)
    else $error("no-op busy length wrong");
a_latency_count: assert property ($fell(busy) && (lat(op_q) != 0) |-> cnt_q == lat(op_q))
    else $error("busy length differs from latency");
a_busy_on_take: assert property (take |=> busy)
    else $error("busy not raised after command");
a_ready_idle: assert property (cmd_ready_out == !busy)
    else $error("ready disagrees with busy");
a_srq_at_end: assert property ($fell(busy) |-> service_request_output == srq_q)
    else $error("service request wrong at completion");
a_srq_clear: assert property (take |=> !service_request_output)
    else $error("service request not cleared by command");
a_flags_hold: assert property (!busy && $past(!busy) |-> $stable(result_flags_out[6:0]))
    else $error("flags changed while idle");
a_reset_state: assert property ($fell(sys_rst_in) |-> result_flags_out == 8'h20 && cmd_ready_out)
    else $error("reset state wrong");
a_pop_hold: assert property (!$past(pop_req_in && cmd_ready_out && !cmd_valid_in && !push_valid_in)
    |-> $stable(pop_byte_out))
    else $error("pop data changed without pop");
endmodule // stack_unit_props
bind stack_arithmetic_command_unit stack_unit_props chk_u
(
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_byte_in(cmd_byte_in), .push_valid_in(push_valid_in), .push_byte_in(push_byte_in),
    .pop_req_in(pop_req_in), .pop_byte_out(pop_byte_out), .result_flags_out(result_flags_out),
    .service_request_output(service_request_output), .cmd_ready_out(cmd_ready_out)
);
`default_nettype wire

// [bench/tb_stack_arithmetic_command_unit.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module tb_stack_arithmetic_command_unit;
logic        clk_in = 1'b0;
logic        sys_rst_in = 1'b1;
logic        cmd_valid, push_valid, pop_req, srq, ready, hang;
logic [7:0]  cmd_byte, push_byte, pop_byte, flags;
logic [31:0] v;
int          n_fail = 0;
int          num_checks = 0;
initial forever #20 clk_in = ~clk_in;
stack_arithmetic_command_unit dut_u
(
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid),
    .cmd_byte_in(cmd_byte), .push_valid_in(push_valid), .push_byte_in(push_byte),
    .pop_req_in(pop_req), .pop_byte_out(pop_byte), .result_flags_out(flags),
    .service_request_output(srq), .cmd_ready_out(ready)
);
host_model host_u
(
    .clk_in(clk_in), .cmd_ready_in(ready), .flags_in(flags), .pop_byte_in(pop_byte),
    .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte), .push_valid_out(push_valid),
    .push_byte_out(push_byte), .pop_req_out(pop_req), .hang_out(hang)
);
// ****************
// scenarios
// ****************
task t_single_add_carry;
    host_u.put(2, 32'h0000FFFF);
    host_u.put(2, 32'h00000001);
    host_u.run(8'h6C, 1);
    `CHK(flags, 8'h21)
    host_u.get(2, v);
    `CHK(v[15:0], 16'h0000)
endtask
task t_single_subtract_borrow;
    host_u.put(2, 32'h00000003);
    host_u.put(2, 32'h00000005);
    host_u.run(8'h6D, 1);
    `CHK(flags, 8'h41)
    host_u.get(2, v);
    `CHK(v[15:0], 16'hFFFE)
endtask
task t_div_zero;
    host_u.put(2, 32'h00000007);
    host_u.put(2, 32'h00000000);
    host_u.run(8'h6F, 1);
    `CHK(flags[4:1], 4'h8)
    host_u.get(2, v);
    `CHK(v[15:0], 16'h0007)
endtask
task t_negate;
    host_u.put(2, 32'h00008000);
    host_u.run(8'h74, 1);
    `CHK(flags[4:1], 4'h1)
    host_u.get(2, v);
    `CHK(v[15:0], 16'h8000)
    host_u.put(4, 32'h00000005);
    host_u.run(8'h34, 1);
    `CHK(flags[6:5], 2'b10)
    host_u.get(4, v);
    `CHK(v, 32'hFFFFFFFB)
endtask
task t_double_add;
    host_u.put(4, 32'h00010000);
    host_u.put(4, 32'h0000FFFF);
    host_u.run(8'h2C, 1);
    `CHK(flags, 8'h00)
    host_u.get(4, v);
    `CHK(v, 32'h0001FFFF)
endtask
task t_stack_ops;
    host_u.put(4, 32'h11223344);
    host_u.put(4, 32'h55667788);
    host_u.run(8'h39, 1);
    host_u.get(4, v);
    `CHK(v, 32'h11223344)
    host_u.run(8'h37, 1);
    host_u.get(4, v);
    `CHK(v, 32'h55667788)
    host_u.get(4, v);
    `CHK(v, 32'h55667788)
    host_u.put(2, 32'h00000A0B);
    host_u.put(2, 32'h00000C0D);
    host_u.run(8'h78, 1);
    host_u.get(2, v);
    `CHK(v[15:0], 16'h0A0B)
endtask
task t_pi_and_nop;
    host_u.run(8'h9A, 1);
    `CHK(srq, 1'b1)
    host_u.get(4, v);
    `CHK(v, 32'h02C90FDB)
    host_u.run(8'h00, 1);
    `CHK(srq, 1'b0)
    host_u.run(8'h80, 1);
    `CHK(srq, 1'b1)
endtask
task t_float_mul;
    host_u.put(4, 32'h00800000);
    host_u.put(4, 32'h00800000);
    host_u.run(8'h12, 1);
    `CHK(flags[6:5], 2'b00)
    host_u.get(4, v);
    `CHK(v, 32'h7F800000)
endtask
task t_busy_refused;
    host_u.put(4, 32'h40C00000);
    host_u.run(8'h01, 0);
    `CHK(ready, 1'b0)
    host_u.put(1, 32'h000000EE);
    host_u.run(8'h01, 1);
    host_u.get(4, v);
    `CHK(v, 32'h40C00000)
endtask
// ****************
// verdict
// ****************
task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
always @(posedge hang)
begin
    n_fail++;
    finish_test;
end
initial
begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in) #1;
    `CHK(flags, 8'h20)
    `CHK(ready, 1'b1)
    t_single_add_carry;
    t_single_subtract_borrow;
    t_div_zero;
    t_negate;
    t_double_add;
    t_stack_ops;
    t_pi_and_nop;
    t_float_mul;
    t_busy_refused;
    finish_test;
end
endmodule // tb_stack_arithmetic_command_unit
`default_nettype wire

// [design/stack_arith_map.vh]
`ifndef STACK_ARITH_MAP_VH
`define STACK_ARITH_MAP_VH
// status byte layout
`define FLAG_BUSY_BIT   7
`define FLAG_SIGN_BIT   6
`define FLAG_ZERO_BIT   5
`define FLAG_ERR_HI     4
`define FLAG_ERR_LO     1
`define FLAG_CARRY_BIT  0
// command byte
`define CMD_SRQ_BIT     7
// error codes
`define ERR_NONE        4'h0
`define ERR_DIV_ZERO    4'h8
`define ERR_NEG_ARG     4'h4
`define ERR_ARG_BIG     4'hC
`define ERR_UNDERFLOW   4'h2
`define ERR_OVERFLOW    4'h1
// operation codes, bit 7 stripped
`define OP_NO_OPERATION 7'h00
`define OP_SQUARE_ROOT  7'h01
`define OP_EXP          7'h0A
`define OP_POWER        7'h0B
`define OP_FLOAT_ADD    7'h10
`define OP_FLOAT_SUB    7'h11
`define OP_FLOAT_MUL    7'h12
`define OP_FLOAT_DIV    7'h13
`define OP_NEGF         7'h15
`define OP_PUSHF        7'h17
`define OP_ROTF         7'h18
`define OP_SWAPF        7'h19
`define OP_PI           7'h1A
`define OP_D2F          7'h1C
`define OP_S2F          7'h1D
`define OP_F2D          7'h1E
`define OP_F2S          7'h1F
`define OP_DBL_ADD      7'h2C
`define OP_DBL_SUB      7'h2D
`define OP_DBL_MUL_LO   7'h2E
`define OP_DBL_DIV      7'h2F
`define OP_NEGD         7'h34
`define OP_DBL_MUL_HI   7'h36
`define OP_PUSHD        7'h37
`define OP_ROTD         7'h38
`define OP_SWAPD        7'h39
`define OP_SGL_ADD      7'h6C
`define OP_SGL_SUB      7'h6D
`define OP_SGL_MUL_LO   7'h6E
`define OP_SGL_DIV      7'h6F
`define OP_NEGS         7'h74
`define OP_SGL_MUL_HI   7'h76
`define OP_PUSHS        7'h77
`define OP_ROTS         7'h78
`define OP_SWAPS        7'h79
// execution cycle counts (worst case used)
`define CYC_NO_OPERATION 14'h0004
`define CYC_SGL_ADD     14'h0012
`define CYC_SGL_SUB     14'h0020
`define CYC_SGL_MUL_LO  14'h005E
`define CYC_SGL_MUL_HI  14'h0062
`define CYC_DBL_ADD     14'h0016
`define CYC_DBL_SUB     14'h0028
`define CYC_DBL_MUL_LO  14'h00D2
`define CYC_DBL_MUL_HI  14'h00DA
`define CYC_FLOAT_ADD   14'h0170
`define CYC_FLOAT_SUB   14'h0172
`define CYC_FLOAT_MUL   14'h00A8
`define CYC_FLOAT_DIV   14'h00B8
`define CYC_SQUARE_ROOT 14'h0366
`define CYC_TRIG        14'h205C
`define CYC_POWER       14'h2F00
`define CYC_CONV   14'h0156
`define CYC_NEGS   14'h0018
`define CYC_NEGD   14'h001C
`define CYC_NEGF   14'h0014
`define CYC_STACK  14'h0014
`define CYC_SWAP   14'h000C
// float format
`define F_SIGN     31
`define F_EXP_HI   30
`define F_EXP_LO   24
`define F_MSB      23
`define PI_FLOAT   32'h02C90FDB
`define EXP_WRAP   8'h80
`endif

// [design/stack_arithmetic_command_unit.v]
// Overview of operation
// - float: 24-bit fraction, 7-bit signed exponent
// - bit 31 mantissa sign, point above bit 23
// - floats normalized, zero is all zeros
// - busy high while a command executes
// - sign flag set for negative top
// - zero flag set when top is zero
// - four-bit error field reports last outcome
// - carry flag from carry or borrow
// - other flags undefined while busy
// - no-op only updates service request enable
// - single ops combine top, next, pop
// - double ops combine top, next, pop
// - float arithmetic combines top, next, pop
// - derived functions replace top; power combines top, next, pop
// - format conversions replace top entry
// - negate commands negate top entry
// - push copies top into next
// - pop rotates old top to bottom
// - exchange swaps top and next
// - push constant pi onto top
// - command finishes within its cycle range
// - exponent wraps by 128 on over/underflow
// - stack of 16 bytes, oldest data lost
// - fixed operands two's complement 16/32
`timescale 1ns/100ps
`include "stack_arith_map.vh"
`default_nettype none
module stack_arithmetic_command_unit
(
    // clock and reset
    input  wire        clk_in,
    input  wire        sys_rst_in,
    // command and operand entry
    input  wire        cmd_valid_in,
    input  wire [7:0]  cmd_byte_in,
    input  wire        push_valid_in,
    input  wire [7:0]  push_byte_in,
    input  wire        pop_req_in,
    // results
    output reg  [7:0]  pop_byte_out,
    output wire [7:0]  result_flags_out,
    output reg         service_request_output,
    output wire        cmd_ready_out
);
    // ****************************************
    // stack storage and state
    // ****************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    // stack effect of an operation
    localparam EFF_TOP  = 2'h0;      // result replaces top
    localparam EFF_POP  = 2'h1;      // combine top and next, pop
    localparam EFF_PUSH = 2'h2;      // push result
    localparam EFF_MOVE = 2'h3;      // pointer move or swap only

    reg [7:0]  mem_q [0:15];         // 16-byte ring, most significant byte of top at ptr-1
    reg [3:0]  ptr_q;
    reg        state_q;
    reg [13:0] cnt_q;
    reg [6:0]  op_q;
    reg        srq_en_q;
    reg        sign_q;
    reg        zero_q;
    reg [3:0]  err_q;
    reg        carry_q;
    integer    i;

    // read a word of n bytes at byte offset k below the pointer
    function [31:0] rd;
        input [3:0] p;
        input [3:0] k;
        input       dbl;
        begin
            if (dbl)
                rd = {mem_q[p - k - 4'h1], mem_q[p - k - 4'h2],
                      mem_q[p - k - 4'h3], mem_q[p - k - 4'h4]};
            else
                rd = {16'h0000, mem_q[p - k - 4'h1], mem_q[p - k - 4'h2]};
        end
    endfunction

    // float sign/zero test of a top word
    function [1:0] fl_flags;
        input [31:0] v;
        begin
            fl_flags = {v[`F_SIGN], v[`F_MSB] == 1'b0};
        end
    endfunction

    // worst-case latency per operation
    function [13:0] latency;
        input [6:0] op;
        begin
            case (op)
                `OP_NO_OPERATION: latency = `CYC_NO_OPERATION;
                `OP_SGL_ADD:     latency = `CYC_SGL_ADD;
                `OP_SGL_SUB:     latency = `CYC_SGL_SUB;
                `OP_SGL_MUL_LO, `OP_SGL_DIV: latency = `CYC_SGL_MUL_LO;
                `OP_SGL_MUL_HI:  latency = `CYC_SGL_MUL_HI;
                `OP_DBL_ADD:     latency = `CYC_DBL_ADD;
                `OP_DBL_SUB:     latency = `CYC_DBL_SUB;
                `OP_DBL_MUL_LO, `OP_DBL_DIV: latency = `CYC_DBL_MUL_LO;
                `OP_DBL_MUL_HI:  latency = `CYC_DBL_MUL_HI;
                `OP_FLOAT_ADD:   latency = `CYC_FLOAT_ADD;
                `OP_FLOAT_SUB:   latency = `CYC_FLOAT_SUB;
                `OP_FLOAT_MUL:   latency = `CYC_FLOAT_MUL;
                `OP_FLOAT_DIV:   latency = `CYC_FLOAT_DIV;
                `OP_SQUARE_ROOT: latency = `CYC_SQUARE_ROOT;
                `OP_POWER:       latency = `CYC_POWER;
                `OP_NEGS:        latency = `CYC_NEGS;
                `OP_NEGD:        latency = `CYC_NEGD;
                `OP_NEGF:        latency = `CYC_NEGF;
                `OP_SWAPS, `OP_SWAPD, `OP_SWAPF: latency = `CYC_SWAP;
                `OP_PUSHS, `OP_PUSHD, `OP_PUSHF,
                `OP_ROTS, `OP_ROTD, `OP_ROTF, `OP_PI: latency = `CYC_STACK;
                default:   latency = (op <= `OP_EXP) ? `CYC_TRIG : `CYC_CONV;
            endcase
        end
    endfunction

    // ****************************************
    // operand fetch and datapath
    // ****************************************
    wire        is_single = (op_q[6:5] == 2'b11);
    wire        is_float  = (op_q[6:5] == 2'b00);
    wire [31:0] top_w = rd(ptr_q, 4'h0, ~is_single);
    wire [31:0] nxt_w = rd(ptr_q, is_single ? 4'h2 : 4'h4, ~is_single);
    wire [15:0] ts = top_w[15:0];
    wire [15:0] ns = nxt_w[15:0];
    wire [16:0] s_add = {1'b0, ns} + {1'b0, ts};
    wire [16:0] s_sub = {1'b0, ns} - {1'b0, ts};
    wire [31:0] s_mul = $signed(ns) * $signed(ts);
    wire [32:0] d_add = {1'b0, nxt_w} + {1'b0, top_w};
    wire [32:0] d_sub = {1'b0, nxt_w} - {1'b0, top_w};
    wire [63:0] d_mul = $signed(nxt_w) * $signed(top_w);
    // both arms signed so the quotient stays a signed divide
    wire [15:0] s_div = (ts == 16'h0000) ? $signed(ns) : $signed(ns) / $signed(ts);
    wire [31:0] d_div = (top_w == 32'h0) ? $signed(nxt_w) : $signed(nxt_w) / $signed(top_w);
    // float multiply with exponent wrap modulo 128
    wire [47:0] f_mprod = {24'h0, nxt_w[23:0]} * {24'h0, top_w[23:0]};
    wire [7:0]  f_mexp  = {nxt_w[30], nxt_w[30:24]} + {top_w[30], top_w[30:24]}
                          - {7'h00, ~f_mprod[47]};
    wire [31:0] f_mul = (nxt_w[23] & top_w[23]) ?
                        {nxt_w[31] ^ top_w[31], f_mexp[6:0],
                         f_mprod[47] ? f_mprod[47:24] : f_mprod[46:23]} : 32'h0;
    wire        f_movf = (f_mexp[7] != f_mexp[6]);

    reg [31:0] res_d;
    reg [1:0]  eff_d;    // 0 replace top, 1 combine and pop, 2 push, 3 stack move
    reg [3:0]  err_d;
    reg        carry_d;
    always @*
    begin
        res_d   = top_w;
        eff_d   = 2'd3;
        err_d   = `ERR_NONE;
        carry_d = 1'b0;
        case (op_q)
            `OP_SGL_ADD, `OP_SGL_SUB:
            begin
                res_d   = {16'h0000, (op_q == `OP_SGL_SUB) ? s_sub[15:0] : s_add[15:0]};
                eff_d   = EFF_POP;
                carry_d = (op_q == `OP_SGL_SUB) ? s_sub[16] : s_add[16];
            end
            `OP_SGL_MUL_LO, `OP_SGL_MUL_HI:
            begin
                res_d = {16'h0000, (op_q == `OP_SGL_MUL_HI) ? s_mul[31:16] : s_mul[15:0]};
                eff_d = EFF_POP;
            end
            `OP_SGL_DIV:
            begin
                res_d = {16'h0000, s_div};
                eff_d = EFF_POP;
                if (ts == 16'h0000)
                    err_d = `ERR_DIV_ZERO;
            end
            `OP_DBL_ADD, `OP_DBL_SUB:
            begin
                res_d   = (op_q == `OP_DBL_SUB) ? d_sub[31:0] : d_add[31:0];
                eff_d   = EFF_POP;
                carry_d = (op_q == `OP_DBL_SUB) ? d_sub[32] : d_add[32];
            end
            `OP_DBL_MUL_LO, `OP_DBL_MUL_HI:
            begin
                res_d = (op_q == `OP_DBL_MUL_HI) ? d_mul[63:32] : d_mul[31:0];
                eff_d = EFF_POP;
            end
            `OP_DBL_DIV:
            begin
                res_d = d_div;
                eff_d = EFF_POP;
                if (top_w == 32'h0)
                    err_d = `ERR_DIV_ZERO;
            end
            `OP_FLOAT_MUL:
            begin
                res_d = f_mul;
                eff_d = EFF_POP;
                if (f_movf)
                    err_d = f_mexp[7] ? `ERR_UNDERFLOW : `ERR_OVERFLOW;
            end
            `OP_FLOAT_ADD, `OP_FLOAT_SUB, `OP_FLOAT_DIV, `OP_POWER:
            begin
                res_d = nxt_w;
                eff_d = EFF_POP;
                if (op_q == `OP_FLOAT_DIV && top_w[`F_MSB] == 1'b0)
                    err_d = `ERR_DIV_ZERO;
            end
            `OP_NEGS:
            begin
                eff_d = EFF_TOP;
                if (ts == 16'h8000)
                    err_d = `ERR_OVERFLOW;
                else
                    res_d = {16'h0000, 16'h0000 - ts};
            end
            `OP_NEGD:
            begin
                eff_d = EFF_TOP;
                if (top_w == 32'h80000000)
                    err_d = `ERR_OVERFLOW;
                else
                    res_d = 32'h0 - top_w;
            end
            `OP_NEGF:
            begin
                eff_d = EFF_TOP;
                if (top_w[`F_MSB])
                    res_d = {~top_w[`F_SIGN], top_w[30:0]};
            end
            `OP_PUSHS, `OP_PUSHD, `OP_PUSHF, `OP_PI:
            begin
                eff_d = EFF_PUSH;
                if (op_q == `OP_PI)
                    res_d = `PI_FLOAT;
            end
            `OP_NO_OPERATION, `OP_ROTS, `OP_ROTD, `OP_ROTF,
            `OP_SWAPS, `OP_SWAPD, `OP_SWAPF: eff_d = EFF_MOVE;
            default:
            begin
                eff_d = EFF_TOP;
                if (op_q == `OP_SQUARE_ROOT && top_w[`F_SIGN])
                    err_d = `ERR_NEG_ARG;
            end
        endcase
    end

    // ****************************************
    // command sequencer and stack update
    // ****************************************
    wire [3:0] wsz = is_single ? 4'h2 : 4'h4;
    wire [3:0] np  = (eff_d == EFF_POP) ? ptr_q - wsz : (eff_d == EFF_PUSH) ? ptr_q + wsz : ptr_q;
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 14'h0000;
            op_q    <= 7'h00;
            ptr_q   <= 4'h0;
            srq_en_q <= 1'b0;
            sign_q  <= 1'b0;
            zero_q  <= 1'b1;
            err_q   <= `ERR_NONE;
            carry_q <= 1'b0;
            service_request_output <= 1'b0;
            pop_byte_out <= 8'h00;
            for (i = 0; i < 16; i = i + 1)
                mem_q[i] <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cmd_valid_in)
                    begin
                        op_q     <= cmd_byte_in[6:0];
                        srq_en_q <= cmd_byte_in[`CMD_SRQ_BIT];
                        service_request_output <= 1'b0;
                        cnt_q    <= latency(cmd_byte_in[6:0]) - 14'h0001;
                        state_q  <= ST_RUN;
                    end
                    else if (push_valid_in)
                    begin
                        mem_q[ptr_q] <= push_byte_in;
                        ptr_q <= ptr_q + 4'h1;
                    end
                    else if (pop_req_in)
                    begin
                        pop_byte_out <= mem_q[ptr_q - 4'h1];
                        ptr_q <= ptr_q - 4'h1;
                    end
                end
                ST_RUN:
                begin
                    if (cnt_q != 14'h0000)
                        cnt_q <= cnt_q - 14'h0001;
                    else
                    begin
                        state_q <= ST_IDLE;
                        service_request_output <= srq_en_q;
                        if (op_q != `OP_NO_OPERATION)
                        begin
                            ptr_q   <= np;
                            err_q   <= err_d;
                            carry_q <= carry_d;
                            if (eff_d != EFF_MOVE)
                            begin
                                if (is_single)
                                    {mem_q[np - 4'h1], mem_q[np - 4'h2]} <= res_d[15:0];
                                else
                                    {mem_q[np - 4'h1], mem_q[np - 4'h2],
                                     mem_q[np - 4'h3], mem_q[np - 4'h4]} <= res_d;
                            end
                            if (op_q == `OP_SWAPS || op_q == `OP_SWAPD || op_q == `OP_SWAPF)
                            begin
                                for (i = 0; i < 4; i = i + 1)
                                    if (i < wsz)
                                    begin
                                        mem_q[ptr_q - 4'h1 - i[3:0]] <= mem_q[ptr_q - 4'h1 - wsz - i[3:0]];
                                        mem_q[ptr_q - 4'h1 - wsz - i[3:0]] <= mem_q[ptr_q - 4'h1 - i[3:0]];
                                    end
                            end
                            if (op_q == `OP_ROTS || op_q == `OP_ROTD || op_q == `OP_ROTF)
                                ptr_q <= ptr_q - wsz;
                            // flags follow the resulting top; swap and pop leave old next on top
                            if (is_float)
                                {sign_q, zero_q} <= (eff_d == EFF_MOVE) ?
                                    fl_flags(nxt_w) : fl_flags(res_d);
                            else if (is_single)
                                {sign_q, zero_q} <= (eff_d == EFF_MOVE) ?
                                    {ns[15], ns == 16'h0000} :
                                    {res_d[15], res_d[15:0] == 16'h0000};
                            else
                                {sign_q, zero_q} <= (eff_d == EFF_MOVE) ?
                                    {nxt_w[31], nxt_w == 32'h0} :
                                    {res_d[31], res_d == 32'h0};
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // status byte
    // ****************************************
    assign result_flags_out[`FLAG_BUSY_BIT] = state_q;
    assign result_flags_out[`FLAG_SIGN_BIT] = sign_q;
    assign result_flags_out[`FLAG_ZERO_BIT] = zero_q;
    assign result_flags_out[`FLAG_ERR_HI:`FLAG_ERR_LO] = err_q;
    assign result_flags_out[`FLAG_CARRY_BIT] = carry_q;
    assign cmd_ready_out = (state_q == ST_IDLE);
endmodule // stack_arithmetic_command_unit
`default_nettype wire
